//--- hw/vpu_pkg.sv
// shared constants, types and helpers for the video port unpacker link
`default_nettype none
package vpu_pkg;
    // video input format codes
    localparam logic [3:0] FMT_YUV8 = 4'h0;
    localparam logic [3:0] FMT_YUV8_SYNC = 4'h1;
    localparam logic [3:0] FMT_RGB565_HL = 4'h2;
    localparam logic [3:0] FMT_RGB565_LH = 4'h3;
    localparam logic [3:0] FMT_YUV16 = 4'h4;
    localparam logic [3:0] FMT_RGB565_W = 4'h5;
    localparam logic [3:0] FMT_RGB666_W = 4'h6;
    localparam logic [3:0] FMT_RGB666_AB = 4'h7;
    localparam logic [3:0] FMT_RGB666_BA = 4'h8;
    localparam logic [3:0] FMT_RGB666_X3 = 4'h9;
    localparam logic [3:0] FMT_RGB888_X3 = 4'ha;
    localparam logic [3:0] FMT_RESET = FMT_YUV8;
    // commands: bit 7 set means a parameter must follow
    localparam int CMD_PARAM_BIT = 7;
    localparam logic [7:0] CMD_SET_VIF_FMT = 8'h80;
    // embedded sync codes
    localparam logic [7:0] SYNC_FF = 8'hff;
    localparam logic [7:0] SYNC_00 = 8'h00;
    localparam int SYNC_H_BIT = 4;
    // colour matrix weights, scaled by 256
    localparam logic signed [17:0] K_YR = 18'sh0_0042;
    localparam logic signed [17:0] K_YG = 18'sh0_0081;
    localparam logic signed [17:0] K_YB = 18'sh0_0019;
    localparam logic signed [17:0] K_UR = 18'sh0_0026;
    localparam logic signed [17:0] K_UG = 18'sh0_004a;
    localparam logic signed [17:0] K_UB = 18'sh0_0070;
    localparam logic signed [17:0] K_VG = 18'sh0_005e;
    localparam logic signed [17:0] K_VB = 18'sh0_0012;
    localparam logic signed [17:0] K_RND = 18'sh0_0080;
    localparam logic [7:0] Y_OFS = 8'h10;
    localparam logic [7:0] C_OFS = 8'h80;
    // host register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_PARAM = 8'h08;
    localparam logic [7:0] REG_PRD = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_PIX = 8'h14;
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_FMT_LSB = 4;
    localparam int CTRL_CFG_LSB = 8;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam int PIX_LS_BIT = 18;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {HS_IDLE, HS_CMD, HS_PHI, HS_PLO, HS_PRD} vpu_hst_e;

    // host bus configs that move commands and parameters a byte at a time
    function automatic logic cfg_is_byte(input logic [3:0] cfg);
        cfg_is_byte = (cfg == 4'h5) || (cfg == 4'h6) || (cfg == 4'h7) || (cfg == 4'h8) ||
                      (cfg == 4'hb) || (cfg == 4'hc) || (cfg == 4'hf);
    endfunction : cfg_is_byte

    function automatic logic cfg_upper_lane(input logic [3:0] cfg);
        cfg_upper_lane = (cfg == 4'h5) || (cfg == 4'h7) || (cfg == 4'hb);
    endfunction : cfg_upper_lane

    // pins that a format uses; all others must be held low
    function automatic logic [17:0] fmt_mask(input logic [3:0] fmt);
        unique case (fmt)
            FMT_YUV16, FMT_RGB565_W, FMT_RGB666_AB, FMT_RGB666_BA: fmt_mask = 18'h0_ffff;
            FMT_RGB666_W: fmt_mask = 18'h3_ffff;
            FMT_RGB666_X3: fmt_mask = 18'h0_003f;
            default: fmt_mask = 18'h0_00ff;
        endcase
    endfunction : fmt_mask
endpackage : vpu_pkg
`default_nettype wire

//--- hw/vpu_link_if.sv
// pins between the video source / host and the display device
`default_nettype none
interface vpu_link_if;
    logic video_port_select_pin;
    logic [15:0] video_pixel_bus;
    logic extended_data_bit_hi;
    logic extended_data_bit_lo;
    logic vp_valid;
    logic vp_line_start;
    logic vp_ready;
    logic [3:0] host_bus_config_pins;
    logic cmd_param_select;
    logic hb_wr;
    logic hb_rd;
    logic [15:0] hb_wdata;
    logic [15:0] hb_rdata;
    logic hb_rdata_oe;

    modport dev (
        input video_port_select_pin, video_pixel_bus, extended_data_bit_hi, extended_data_bit_lo,
        input vp_valid, vp_line_start, host_bus_config_pins, cmd_param_select, hb_wr, hb_rd, hb_wdata,
        output vp_ready, hb_rdata, hb_rdata_oe
    );
    modport host (
        output video_port_select_pin, video_pixel_bus, extended_data_bit_hi, extended_data_bit_lo,
        output vp_valid, vp_line_start, host_bus_config_pins, cmd_param_select, hb_wr, hb_rd, hb_wdata,
        input vp_ready, hb_rdata, hb_rdata_oe
    );
endinterface : vpu_link_if
`default_nettype wire

//--- hw/vpu_dev_end.sv
// device end: video port unpacker, colour matrix and command decoder
`default_nettype none
module vpu_dev_end (
    input wire logic pclk,
    input wire logic presetn,
    vpu_link_if.dev link,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [16:0] pix_data,
    output logic [3:0] video_format,
    output logic cmd_exec,
    output logic cmd_cancel,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_param
);
    logic [3:0] fmt_q;
    logic [1:0] cnt_q;
    logic [17:0] h0_q;
    logic [17:0] h1_q;
    logic [1:0] sync_q;
    logic active_q;
    logic cflag_q;
    logic out_valid_q;
    logic [16:0] out_q;
    logic pend_q;
    logic half_q;
    logic [7:0] code_q;
    logic [7:0] hi_q;
    logic exec_q;
    logic cancel_q;
    logic [15:0] param_q;
    logic [15:0] rdata_q;

    // the video port data pins are input only; of the video port pins only vp_ready is driven here
    wire logic [17:0] d = {link.extended_data_bit_hi, link.extended_data_bit_lo, link.video_pixel_bus};
    wire logic [7:0] lo_byte = d[7:0];
    wire logic fmt_legal = fmt_q <= vpu_pkg::FMT_RGB888_X3;
    wire logic vp_ready_w = !out_valid_q || pix_ready;
    wire logic take = link.vp_valid && vp_ready_w && link.video_port_select_pin && fmt_legal;
    wire logic sync_fmt = fmt_q == vpu_pkg::FMT_YUV8_SYNC;
    wire logic in_sync = sync_fmt && (sync_q != 2'h0 || lo_byte == vpu_pkg::SYNC_FF);
    wire logic pix_take = take && !in_sync && (!sync_fmt || active_q);
    wire logic sync_take = take && in_sync;
    wire logic [1:0] cur_cnt = link.vp_line_start ? 2'h0 : cnt_q;
    wire logic cur_flag = link.vp_line_start ? 1'b0 : cflag_q;
    logic [1:0] last_cnt;
    wire logic final_xfer = pix_take && (cur_cnt == last_cnt);

    assign link.vp_ready = vp_ready_w;
    assign pix_valid = out_valid_q;
    assign pix_data = out_q;
    assign video_format = fmt_q;
    assign cmd_exec = exec_q;
    assign cmd_cancel = cancel_q;
    assign cmd_code = code_q;
    assign cmd_param = param_q;

    function automatic logic [7:0] ex5(input logic [4:0] x);
        ex5 = {x, x[4:2]};
    endfunction : ex5

    function automatic logic [7:0] ex6(input logic [5:0] x);
        ex6 = {x, x[5:4]};
    endfunction : ex6

    // index of the last transfer of a pixel for each packing
    always_comb
    begin
        unique case (fmt_q)
            vpu_pkg::FMT_YUV16, vpu_pkg::FMT_RGB565_W, vpu_pkg::FMT_RGB666_W: last_cnt = 2'h0;
            vpu_pkg::FMT_RGB666_X3, vpu_pkg::FMT_RGB888_X3: last_cnt = 2'h2;
            default: last_cnt = 2'h1;
        endcase
    end

    logic is_rgb;
    logic [7:0] r8;
    logic [7:0] g8;
    logic [7:0] b8;
    logic [7:0] y_in;
    logic [7:0] c_in;

    // unpack the final transfer together with the held earlier ones
    always_comb
    begin
        is_rgb = 1'b1;
        r8 = 8'h00;
        g8 = 8'h00;
        b8 = 8'h00;
        y_in = 8'h00;
        c_in = 8'h00;
        unique case (fmt_q)
            vpu_pkg::FMT_YUV8, vpu_pkg::FMT_YUV8_SYNC:
            begin
                is_rgb = 1'b0;
                y_in = d[7:0];
                c_in = h0_q[7:0];
            end
            vpu_pkg::FMT_YUV16:
            begin
                is_rgb = 1'b0;
                y_in = d[15:8];
                c_in = d[7:0];
            end
            vpu_pkg::FMT_RGB565_HL:
            begin
                r8 = ex5(h0_q[7:3]);
                g8 = ex6({h0_q[2:0], d[7:5]});
                b8 = ex5(d[4:0]);
            end
            vpu_pkg::FMT_RGB565_LH:
            begin
                r8 = ex5(d[7:3]);
                g8 = ex6({d[2:0], h0_q[7:5]});
                b8 = ex5(h0_q[4:0]);
            end
            vpu_pkg::FMT_RGB565_W:
            begin
                r8 = ex5(d[15:11]);
                g8 = ex6(d[10:5]);
                b8 = ex5(d[4:0]);
            end
            vpu_pkg::FMT_RGB666_W:
            begin
                r8 = ex6(d[17:12]);
                g8 = ex6(d[11:6]);
                b8 = ex6(d[5:0]);
            end
            vpu_pkg::FMT_RGB666_AB:
            begin
                r8 = ex6(h0_q[15:10]);
                g8 = ex6(h0_q[9:4]);
                b8 = ex6({h0_q[3:0], d[15:14]});
            end
            vpu_pkg::FMT_RGB666_BA:
            begin
                r8 = ex6({h0_q[15:14], d[15:12]});
                g8 = ex6(d[11:6]);
                b8 = ex6(d[5:0]);
            end
            vpu_pkg::FMT_RGB666_X3:
            begin
                r8 = ex6(h0_q[5:0]);
                g8 = ex6(h1_q[5:0]);
                b8 = ex6(d[5:0]);
            end
            vpu_pkg::FMT_RGB888_X3:
            begin
                r8 = h0_q[7:0];
                g8 = h1_q[7:0];
                b8 = d[7:0];
            end
            default:
            begin
                is_rgb = 1'b0;
            end
        endcase
    end

    // fixed-point matrix; chroma is subsampled by alternating U and V per pixel
    wire logic signed [17:0] rs = $signed({10'h000, r8});
    wire logic signed [17:0] gs = $signed({10'h000, g8});
    wire logic signed [17:0] bs = $signed({10'h000, b8});
    wire logic signed [17:0] y_sum = vpu_pkg::K_YR * rs + vpu_pkg::K_YG * gs + vpu_pkg::K_YB * bs + vpu_pkg::K_RND;
    wire logic signed [17:0] u_sum = vpu_pkg::K_UB * bs - vpu_pkg::K_UR * rs - vpu_pkg::K_UG * gs + vpu_pkg::K_RND;
    wire logic signed [17:0] v_sum = vpu_pkg::K_UB * rs - vpu_pkg::K_VG * gs - vpu_pkg::K_VB * bs + vpu_pkg::K_RND;
    wire logic [7:0] y_rgb = y_sum[15:8] + vpu_pkg::Y_OFS;
    wire logic [7:0] c_rgb = (cur_flag ? v_sum[15:8] : u_sum[15:8]) + vpu_pkg::C_OFS;
    wire logic [7:0] y_out = is_rgb ? y_rgb : y_in;
    wire logic [7:0] c_out = is_rgb ? c_rgb : c_in;

    // transfer counter and holding registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 2'h0;
            h0_q <= 18'h0_0000;
            h1_q <= 18'h0_0000;
            cflag_q <= 1'b0;
        end
        else if (exec_q && code_q == vpu_pkg::CMD_SET_VIF_FMT)
        begin
            cnt_q <= 2'h0;
            cflag_q <= 1'b0;
        end
        else if (sync_take && sync_q == 2'h3)
        begin
            cnt_q <= 2'h0;
            cflag_q <= 1'b0;
        end
        else if (pix_take)
        begin
            cnt_q <= final_xfer ? 2'h0 : cur_cnt + 2'h1;
            cflag_q <= final_xfer ? !cur_flag : cur_flag;
            if (cur_cnt == 2'h0)
                h0_q <= d;
            if (cur_cnt == 2'h1)
                h1_q <= d;
        end
    end

    // embedded sync: FF 00 00 then a status byte whose H bit marks line end/start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_q <= 2'h0;
            active_q <= 1'b0;
        end
        else if (sync_take)
        begin
            unique case (sync_q)
                2'h0: sync_q <= 2'h1;
                2'h1: sync_q <= (lo_byte == vpu_pkg::SYNC_00) ? 2'h2 : {1'b0, lo_byte == vpu_pkg::SYNC_FF};
                2'h2: sync_q <= (lo_byte == vpu_pkg::SYNC_00) ? 2'h3 : 2'h0;
                2'h3:
                begin
                    sync_q <= 2'h0;
                    active_q <= !lo_byte[vpu_pkg::SYNC_H_BIT];
                end
            endcase
        end
    end

    // output stage holds a pixel until the consumer takes it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid_q <= 1'b0;
            out_q <= 17'h0_0000;
        end
        else if (final_xfer)
        begin
            out_valid_q <= 1'b1;
            out_q <= {cur_flag, y_out, c_out};
        end
        else if (pix_ready)
        begin
            out_valid_q <= 1'b0;
        end
    end

    // command decoder
    wire logic is_byte = vpu_pkg::cfg_is_byte(link.host_bus_config_pins);
    wire logic upper = vpu_pkg::cfg_upper_lane(link.host_bus_config_pins);
    wire logic [7:0] lane = upper ? link.hb_wdata[15:8] : link.hb_wdata[7:0];
    wire logic cmd_wr = link.hb_wr && !link.cmd_param_select;
    wire logic par_wr = link.hb_wr && link.cmd_param_select && pend_q;
    wire logic needs_par = lane[vpu_pkg::CMD_PARAM_BIT];
    wire logic par_done = par_wr && (!is_byte || half_q);
    wire logic [15:0] par_word = is_byte ? {hi_q, lane} : link.hb_wdata;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 1'b0;
            half_q <= 1'b0;
            code_q <= 8'h00;
            hi_q <= 8'h00;
            exec_q <= 1'b0;
            cancel_q <= 1'b0;
            param_q <= 16'h0000;
        end
        else
        begin
            exec_q <= (cmd_wr && !needs_par) || par_done;
            cancel_q <= cmd_wr && pend_q;
            if (cmd_wr)
            begin
                code_q <= lane;
                pend_q <= needs_par;
                half_q <= 1'b0;
            end
            else if (par_done)
            begin
                param_q <= par_word;
                pend_q <= 1'b0;
                half_q <= 1'b0;
            end
            else if (par_wr)
            begin
                hi_q <= lane;
                half_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fmt_q <= vpu_pkg::FMT_RESET;
        else if (exec_q && code_q == vpu_pkg::CMD_SET_VIF_FMT)
            fmt_q <= param_q[3:0];
    end

    // status byte on both lanes so either lane choice reads it
    wire logic [7:0] stat = {pend_q, half_q, 2'b00, fmt_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 16'h0000;
        else
            rdata_q <= {stat, stat};
    end

    assign link.hb_rdata = rdata_q;
    assign link.hb_rdata_oe = link.hb_rd && link.cmd_param_select;
endmodule : vpu_dev_end
`default_nettype wire

//--- hw/vpu_host_end.sv
// host end: APB register front, pixel FIFO and link sequencer
`default_nettype none
module vpu_fifo #(
    parameter int W = 19,
    parameter int DEPTH = vpu_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    // depth must be a power of two: pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire logic full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire logic empty = wp_q == rp_q;
    wire logic push = in_valid && !full;
    wire logic pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_q[AW-1:0]];

    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wp_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule : vpu_fifo

module vpu_host_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vpu_link_if.host link
);
    logic [11:0] ctrl_q;
    logic [15:0] par_q;
    logic [15:0] wdata_q;
    logic [15:0] wdata_d;
    logic [15:0] rd_q;
    vpu_pkg::vpu_hst_e st_q;
    vpu_pkg::vpu_hst_e st_d;
    logic f_ir;
    logic f_ov;
    logic [18:0] f_od;

    wire logic [3:0] fmt = ctrl_q[vpu_pkg::CTRL_FMT_LSB +: 4];
    wire logic [3:0] cfg = ctrl_q[vpu_pkg::CTRL_CFG_LSB +: 4];
    wire logic sel = ctrl_q[vpu_pkg::CTRL_SEL_BIT];
    wire logic byte_mode = vpu_pkg::cfg_is_byte(cfg);
    wire logic upper = vpu_pkg::cfg_upper_lane(cfg);
    wire logic hit_ctrl = paddr == vpu_pkg::REG_CTRL;
    wire logic hit_cmd = paddr == vpu_pkg::REG_CMD;
    wire logic hit_par = paddr == vpu_pkg::REG_PARAM;
    wire logic hit_prd = paddr == vpu_pkg::REG_PRD;
    wire logic hit_stat = paddr == vpu_pkg::REG_STAT;
    wire logic hit_pix = paddr == vpu_pkg::REG_PIX;
    wire logic mapped = hit_ctrl || hit_cmd || hit_par || hit_prd || hit_stat || hit_pix;
    wire logic idle = st_q == vpu_pkg::HS_IDLE;
    wire logic link_wr = pwrite && (hit_cmd || hit_par || hit_prd);
    wire logic wr_go = psel && penable && pwrite && pready;

    // link writes wait for the sequencer, pixel writes for FIFO room
    assign pready = link_wr ? idle : ((pwrite && hit_pix) ? f_ir : 1'b1);
    assign pslverr = psel && penable && !mapped;

    function automatic logic [15:0] place(input logic b_upper, input logic [7:0] b);
        place = b_upper ? {b, 8'h00} : {8'h00, b};
    endfunction : place

    always_comb
    begin
        st_d = st_q;
        wdata_d = wdata_q;
        unique case (st_q)
            vpu_pkg::HS_IDLE:
            begin
                if (wr_go && hit_cmd)
                begin
                    st_d = vpu_pkg::HS_CMD;
                    wdata_d = place(upper, pwdata[7:0]);
                end
                else if (wr_go && hit_par)
                begin
                    st_d = vpu_pkg::HS_PHI;
                    wdata_d = byte_mode ? place(upper, pwdata[15:8]) : pwdata[15:0];
                end
                else if (wr_go && hit_prd)
                begin
                    st_d = vpu_pkg::HS_PRD;
                end
            end
            vpu_pkg::HS_PHI:
            begin
                st_d = byte_mode ? vpu_pkg::HS_PLO : vpu_pkg::HS_IDLE;
                wdata_d = place(upper, par_q[7:0]);
            end
            default: st_d = vpu_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= vpu_pkg::HS_IDLE;
            wdata_q <= 16'h0000;
            ctrl_q <= vpu_pkg::CTRL_RESET;
            par_q <= 16'h0000;
            rd_q <= 16'h0000;
        end
        else
        begin
            st_q <= st_d;
            wdata_q <= wdata_d;
            if (wr_go && hit_ctrl)
                ctrl_q <= pwdata[11:0];
            if (wr_go && hit_par)
                par_q <= pwdata[15:0];
            if (st_q == vpu_pkg::HS_PRD && link.hb_rdata_oe)
                rd_q <= link.hb_rdata;
        end
    end

    // command when select low, parameter when high
    assign link.hb_wr = st_q inside {vpu_pkg::HS_CMD, vpu_pkg::HS_PHI, vpu_pkg::HS_PLO};
    assign link.hb_rd = st_q == vpu_pkg::HS_PRD;
    assign link.cmd_param_select = st_q != vpu_pkg::HS_CMD;
    assign link.hb_wdata = wdata_q;
    assign link.host_bus_config_pins = cfg;
    assign link.video_port_select_pin = sel;

    // unused pins are zeroed on entry so the FIFO never carries them
    wire logic [18:0] f_in = {pwdata[vpu_pkg::PIX_LS_BIT], pwdata[17:0] & vpu_pkg::fmt_mask(fmt)};

    vpu_fifo #(.W(19), .DEPTH(vpu_pkg::FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr_go && hit_pix),
        .in_ready(f_ir),
        .in_data(f_in),
        .out_valid(f_ov),
        .out_ready(link.vp_ready && sel),
        .out_data(f_od)
    );

    assign link.vp_valid = f_ov && sel;
    assign link.vp_line_start = f_od[18];
    assign link.extended_data_bit_hi = f_od[17];
    assign link.extended_data_bit_lo = f_od[16];
    assign link.video_pixel_bus = f_od[15:0];

    assign prdata = hit_ctrl ? {20'h0_0000, ctrl_q} :
                    hit_prd ? {16'h0000, rd_q} :
                    hit_stat ? {30'h0000_0000, !f_ir, !idle} : 32'h0000_0000;
endmodule : vpu_host_end
`default_nettype wire

//--- sim/vpu_link_props.sv
// assertions on the pins between the host end and the device end
`default_nettype none
module vpu_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic video_port_select_pin,
    input wire logic [15:0] video_pixel_bus,
    input wire logic vp_valid,
    input wire logic vp_line_start,
    input wire logic vp_ready,
    input wire logic cmd_param_select,
    input wire logic hb_wr,
    input wire logic hb_rd,
    input wire logic hb_rdata_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    oe_match_a: assert property (hb_rdata_oe == (hb_rd && cmd_param_select))
        else $error("read drive wrong");
    rd_is_param_a: assert property (hb_rd |-> cmd_param_select)
        else $error("read without parameter select");
    wr_no_drive_a: assert property (hb_wr |-> !hb_rdata_oe)
        else $error("device drives during write");
    cmd_pulse_a: assert property (hb_wr && !cmd_param_select |=> !hb_wr)
        else $error("command write longer than a pulse");
    rw_excl_a: assert property (!(hb_wr && hb_rd))
        else $error("read and write together");
    word_hold_a: assert property (vp_valid && !vp_ready |=> vp_valid && $stable(video_pixel_bus)
        && $stable(vp_line_start)) else $error("stalled word changed");
    sel_high_a: assert property (vp_valid |-> video_port_select_pin)
        else $error("video word without port select");
    stall_bound_a: assert property (vp_valid |-> ##[0:16] vp_ready)
        else $error("video port stalled too long");
    cover property (hb_wr && !cmd_param_select);
    cover property (vp_valid && vp_ready && vp_line_start);
    cover property (hb_rd);
endmodule : vpu_link_props
`default_nettype wire

//--- sim/tb_video_port_pixel_unpacker.sv
// self-checking bench: host end and device end joined over the link
`default_nettype none
module tb_video_port_pixel_unpacker;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [3:0] f; logic [1:0] n; logic [18:0] w [3]; logic [16:0] x;} vpu_row_s;
    logic pclk = 0;
    logic presetn = 0;
    logic [7:0] paddr = 8'h00;
    logic psel = 0, penable = 0, pwrite = 0, pix_ready = 1, seen = 0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, pix_valid, cmd_cancel, cmd_exec;
    logic [7:0] cmd_code;
    logic [15:0] cmd_param;
    logic [16:0] pix_data;
    logic [3:0] video_format;
    logic [16:0] got [$];
    int errors = 0, compares = 0, cyc = 0, execs = 0;
    logic [18:0] sync_w [7] = '{19'h4_0034, 19'h0_00ff, 0, 0, 0, 19'h0_0034, 19'h0_0012};
    // each row opens a line, so chroma is always U; red and white expose the matrix
    vpu_row_s rows [10] = '{'{4, 1, '{19'h4_1234, 0, 0}, 17'h0_1234}, '{5, 1, '{19'h4_ffff, 0, 0}, 17'h0_eb80},
        '{0, 2, '{19'h4_0034, 19'h0_0012, 0}, 17'h0_1234}, '{2, 2, '{19'h4_00f8, 0, 0}, 17'h0_525a},
        '{3, 2, '{19'h4_0000, 19'h0_00f8, 0}, 17'h0_525a}, '{6, 1, '{19'h7_ffff, 0, 0}, 17'h0_eb80},
        '{7, 2, '{19'h4_fc00, 0, 0}, 17'h0_525a}, '{8, 2, '{19'h4_c000, 19'h0_f000, 0}, 17'h0_525a},
        '{9, 3, '{19'h4_003f, 19'h0_003f, 19'h0_003f}, 17'h0_eb80}, '{10, 3, '{19'h4_00ff, 0, 0}, 17'h0_525a}};
    vpu_link_if link ();
    vpu_host_end u_vpu_host_end (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    vpu_dev_end u_vpu_dev_end (.pclk(pclk), .presetn(presetn), .link(link.dev), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data), .video_format(video_format), .cmd_exec(cmd_exec),
        .cmd_cancel(cmd_cancel), .cmd_code(cmd_code), .cmd_param(cmd_param));
    vpu_link_props u_vpu_link_props (.pclk(pclk), .presetn(presetn),
        .video_port_select_pin(link.video_port_select_pin), .video_pixel_bus(link.video_pixel_bus),
        .vp_valid(link.vp_valid), .vp_line_start(link.vp_line_start), .vp_ready(link.vp_ready),
        .cmd_param_select(link.cmd_param_select), .hb_wr(link.hb_wr), .hb_rd(link.hb_rd),
        .hb_rdata_oe(link.hb_rdata_oe));
    always #20 pclk = ~pclk;
    task end_of_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask : chk
    // read right after the edge, before the design updates: what that edge sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (pix_valid === 1'b1 && pix_ready === 1'b1)
            got.push_back(pix_data);
        if (cmd_cancel === 1'b1)
            seen <= 1;
        if (cmd_exec === 1'b1)
            execs <= execs + 1;
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(video_format, 0);
        foreach (rows[i])
        begin
            apb(1, vpu_pkg::REG_CTRL, {rows[i].f, 4'h1});
            apb(1, vpu_pkg::REG_CMD, vpu_pkg::CMD_SET_VIF_FMT);
            apb(1, vpu_pkg::REG_PARAM, rows[i].f);
            for (int k = 0; k < rows[i].n; k++)
                apb(1, vpu_pkg::REG_PIX, rows[i].w[k]);
            for (int k = 0; k < 60 && got.size() == 0; k++)
                @(posedge pclk);
            chk(video_format, rows[i].f);
            chk(got.pop_front(), rows[i].x);
        end
        pix_ready <= 0;
        for (int k = 0; k < 3; k++)
            apb(1, vpu_pkg::REG_PIX, rows[9].w[k]);
        apb(1, vpu_pkg::REG_PIX, 19'h0_00ff);
        repeat (4) @(posedge pclk);
        pix_ready <= 1;
        apb(1, vpu_pkg::REG_PIX, 0);
        apb(1, vpu_pkg::REG_PIX, 0);
        apb(1, vpu_pkg::REG_CMD, vpu_pkg::CMD_SET_VIF_FMT);
        apb(1, vpu_pkg::REG_PARAM, 1);
        foreach (sync_w[k])
            apb(1, vpu_pkg::REG_PIX, sync_w[k]);
        repeat (4) @(posedge pclk);
        chk(got.pop_front(), 17'h0_525a);
        chk(got.pop_front(), 17'h1_52f0);
        chk(got.pop_front(), 17'h0_1234);
        apb(1, vpu_pkg::REG_CTRL, 32'h0000_0501);
        apb(1, vpu_pkg::REG_CMD, vpu_pkg::CMD_SET_VIF_FMT);
        apb(1, vpu_pkg::REG_PARAM, 32'h0000_0004);
        repeat (4) @(posedge pclk);
        chk(video_format, 4'h4);
        apb(1, vpu_pkg::REG_CTRL, 32'h0000_0601);
        apb(1, vpu_pkg::REG_CMD, vpu_pkg::CMD_SET_VIF_FMT);
        apb(1, vpu_pkg::REG_PARAM, 32'h0000_000a);
        apb(1, vpu_pkg::REG_CMD, vpu_pkg::CMD_SET_VIF_FMT);
        apb(1, vpu_pkg::REG_CMD, 32'h0000_0001);
        apb(1, vpu_pkg::REG_PARAM, 32'h0000_0004);
        repeat (4) @(posedge pclk);
        chk(seen, 1);
        chk(video_format, 4'ha);
        apb(1, vpu_pkg::REG_PRD, 0);
        apb(0, vpu_pkg::REG_PRD, 0);
        chk(rd[15:0], 16'h0a0a);
        apb(0, 8'h40, 0);
        chk(err, 1);
        chk(rd, 0);
        chk(cmd_code, 8'h01);
        chk(cmd_param, 16'h000a);
        chk(execs, 14);
        end_of_test();
    end
endmodule : tb_video_port_pixel_unpacker
`default_nettype wire
